// [core/dsu_arith_shift.sv]
// Purpose: Combinational arithmetic shifter on a guarded operand
// Assumes: Amount is signed, negative shifts right
// Notes: Overflow means the result leaves the unguarded base range
`timescale 1ns/1ns

module dsu_arith_shift #(
    parameter int W = 40,
    parameter int AW = 7,
    parameter int BASE_MSB = 31
) (
    // Operand and amount
    input wire logic [W-1:0] src,
    input wire logic [AW-1:0] amt,
    // Results
    output logic [W-1:0] res,
    output logic last_out,
    output logic ovf
);
    logic [AW-1:0] mag;
    logic [W:0] lsh;
    logic signed [W:0] rsh;
    logic signed [2*W-1:0] wide;
    logic [2*W-1-BASE_MSB:0] top;

    // Magnitude of the signed amount
    assign mag = amt[AW-1] ? AW'(-amt) : amt;
    // Left shift keeps the last bit out in the extra top bit
    assign lsh = {1'b0, src} << mag;
    // Right shift keeps the last bit out in the extra low bit
    assign rsh = $signed({src, 1'b0}) >>> mag;
    // Full-width copy to see bits lost past the guard
    assign wide = (2*W)'($signed(src)) <<< mag;
    assign top = wide[2*W-1:BASE_MSB];

    // Pick direction and flag overflow of the base range
    always_comb begin
        if (amt[AW-1]) begin
            res = rsh[W:1];
            last_out = rsh[0];
        end else begin
            res = lsh[W-1:0];
            last_out = (mag == '0) ? 1'b0 : lsh[W];
        end
        ovf = ~((&top) | ~(|top));
        if (amt[AW-1]) begin
            ovf = ~((&src[W-1:BASE_MSB]) | ~(|src[W-1:BASE_MSB]))
                & ~((&res[W-1:BASE_MSB]) | ~(|res[W-1:BASE_MSB]));
        end
    end

endmodule : dsu_arith_shift

// [core/dsu_logic_shift.sv]
// Purpose: Combinational logical shifter on one 16-bit word
// Assumes: Amount is signed, negative shifts right
// Notes: Zeros fill from either end
`timescale 1ns/1ns

module dsu_logic_shift #(
    parameter int W = 16,
    parameter int AW = 6
) (
    // Operand and amount
    input wire logic [W-1:0] src,
    input wire logic [AW-1:0] amt,
    // Results
    output logic [W-1:0] res,
    output logic last_out
);
    logic [AW-1:0] mag;
    logic [W:0] lsh;
    logic [W:0] rsh;

    // Magnitude and both shift directions with the bit shifted out
    assign mag = amt[AW-1] ? AW'(-amt) : amt;
    assign lsh = {1'b0, src} << mag;
    assign rsh = {src, 1'b0} >> mag;

    // Select by sign of the amount
    always_comb begin
        if (amt[AW-1]) begin
            res = rsh[W:1];
            last_out = rsh[0];
        end else begin
            res = lsh[W-1:0];
            last_out = (mag == '0) ? 1'b0 : lsh[W];
        end
    end

endmodule : dsu_logic_shift

// [core/dsu_params.svh]
// Purpose: Constants of the DSP shift datapath
// Assumes: Included by the package, by the shift unit and by the bench files
// Notes: Offsets here are bit positions inside 40-bit DSP operands
`ifndef DSU_PARAMS_SVH
`define DSU_PARAMS_SVH

// Operand layout
`define DSU_OPND_W 40
`define DSU_BASE_W 32
`define DSU_GUARD_W 8
`define DSU_WORD_W 16
`define DSU_UPPER_LSB 16
`define DSU_BASE_MSB 31

// Shift amount fields inside the second source
`define DSU_ASH_AMT_W 7
`define DSU_ASH_AMT_MSB 22
`define DSU_LSH_AMT_W 6
`define DSU_LSH_AMT_MSB 21
`define DSU_AMT_LSB 16

// Condition select codes
`define DSU_CS_CARRY 3'h0
`define DSU_CS_NEG 3'h1
`define DSU_CS_ZERO 3'h2
`define DSU_CS_OVF 3'h3
`define DSU_CS_ABOVE 3'h4
`define DSU_CS_GE 3'h5

// Saturation values and reset values
`define DSU_SAT_POS 40'h007fffffff
`define DSU_SAT_NEG 40'hff80000000
`define DSU_RESULT_RST 40'h0000000000

`endif

// [core/dsu_pkg.sv]
// Purpose: Types of the DSP shift datapath
// Assumes: dsu_params.svh supplies all figures but the shift kind codes
// Notes: Operation kinds are one-hot
`include "dsu_params.svh"

package dsu_pkg;

    // Shift kind, one-hot
    typedef enum logic [1:0] {
        DSU_OP_ARITH = 2'b01,
        DSU_OP_LOGIC = 2'b10
    } dsu_op_e;

    // Condition select modes
    typedef enum logic [2:0] {
        DSU_CS_CARRY_M = `DSU_CS_CARRY,
        DSU_CS_NEG_M = `DSU_CS_NEG,
        DSU_CS_ZERO_M = `DSU_CS_ZERO,
        DSU_CS_OVF_M = `DSU_CS_OVF,
        DSU_CS_ABOVE_M = `DSU_CS_ABOVE,
        DSU_CS_GE_M = `DSU_CS_GE
    } dsu_cs_e;

    // Condition flags of the DSP status register
    typedef struct packed {
        logic selectable_condition_flag;
        logic neg;
        logic zero;
        logic ovf;
        logic greater_than_flag;
    } dsu_flags_s;

    // Whole state of the shift unit
    typedef struct packed {
        logic valid;
        logic flags_we;
        logic guard_we;
        logic [`DSU_OPND_W-1:0] result;
        dsu_flags_s flags;
    } dsu_state_s;

endpackage : dsu_pkg

// [core/dsu_shift_unit.sv]
// Purpose: Shift datapath of the DSP unit, arithmetic and logical
// Assumes: Issue signals come from the pipeline on SYS_CLK
// Notes: Result and flags appear one cycle after issue
`timescale 1ns/1ns
`include "dsu_params.svh"

module dsu_shift_unit (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Issue from the pipeline
    input wire logic OP_VALID,
    input wire dsu_pkg::dsu_op_e OP_KIND,
    input wire logic COND_OP,
    input wire logic USE_LITERAL,
    input wire logic [`DSU_ASH_AMT_W-1:0] ARITH_SHIFT_LITERAL,
    input wire logic [`DSU_LSH_AMT_W-1:0] LOGIC_SHIFT_LITERAL,
    input wire logic [`DSU_OPND_W-1:0] FIRST_SOURCE,
    input wire logic [`DSU_OPND_W-1:0] SECOND_SOURCE,
    input wire logic SRC_HAS_GUARD,
    input wire logic DST_HAS_GUARD,
    // Status register controls
    input wire dsu_pkg::dsu_cs_e COND_SELECT,
    input wire logic SAT_ENABLE,
    // Results to the register file and status register
    output logic RESULT_VALID,
    output logic [`DSU_OPND_W-1:0] RESULT,
    output logic GUARD_WRITE,
    output logic FLAGS_UPDATE,
    output dsu_pkg::dsu_flags_s FLAGS
);
    import dsu_pkg::*;

    dsu_state_s st_r;
    dsu_state_s st_nxt;

    logic [`DSU_OPND_W-1:0] a_src;
    logic [`DSU_ASH_AMT_W-1:0] a_amt;
    logic [`DSU_OPND_W-1:0] a_res;
    logic a_last;
    logic a_ovf;
    logic [`DSU_LSH_AMT_W-1:0] l_amt;
    logic [`DSU_WORD_W-1:0] l_res;
    logic l_last;
    logic op_legal;

    // Guard positions of an unguarded source take its sign
    assign a_src = SRC_HAS_GUARD ? FIRST_SOURCE :
        {{`DSU_GUARD_W{FIRST_SOURCE[`DSU_BASE_MSB]}},
         FIRST_SOURCE[`DSU_BASE_W-1:0]};

    // Amount from literal or from the upper word of the second source
    assign a_amt = USE_LITERAL ? ARITH_SHIFT_LITERAL :
        SECOND_SOURCE[`DSU_ASH_AMT_MSB:`DSU_AMT_LSB];
    assign l_amt = USE_LITERAL ? LOGIC_SHIFT_LITERAL :
        SECOND_SOURCE[`DSU_LSH_AMT_MSB:`DSU_AMT_LSB];

    // Full 40-bit arithmetic shifter
    dsu_arith_shift #(
        .W(`DSU_OPND_W),
        .AW(`DSU_ASH_AMT_W),
        .BASE_MSB(`DSU_BASE_MSB)
    ) u_arith (
        .src(a_src),
        .amt(a_amt),
        .res(a_res),
        .last_out(a_last),
        .ovf(a_ovf)
    );

    // Upper-word logical shifter
    dsu_logic_shift #(
        .W(`DSU_WORD_W),
        .AW(`DSU_LSH_AMT_W)
    ) u_logic (
        .src(FIRST_SOURCE[`DSU_BASE_MSB:`DSU_UPPER_LSB]),
        .amt(l_amt),
        .res(l_res),
        .last_out(l_last)
    );

    // Next state: result and flags of the DSP stage
    always_comb begin
        logic [`DSU_OPND_W-1:0] r;
        logic last;
        logic ovf;
        dsu_flags_s f;
        r = `DSU_RESULT_RST;
        last = 1'b0;
        ovf = 1'b0;
        f = st_r.flags;
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        st_nxt.flags_we = 1'b0;
        if (OP_VALID) begin
            st_nxt.valid = 1'b1;
            st_nxt.flags_we = ~COND_OP;
            case (OP_KIND)
                DSU_OP_ARITH: begin
                    r = a_res;
                    last = a_last;
                    ovf = a_ovf;
                    if (SAT_ENABLE && a_ovf) begin
                        r = a_src[`DSU_OPND_W-1] ? `DSU_SAT_NEG
                            : `DSU_SAT_POS;
                    end
                    if (SAT_ENABLE) begin
                        ovf = 1'b0;
                    end
                    // Dedicated flags follow their own modes
                    f.neg = r[`DSU_OPND_W-1];
                    f.zero = (r == '0);
                    f.ovf = ovf;
                    f.greater_than_flag = 1'b0;
                    st_nxt.guard_we = DST_HAS_GUARD;
                end
                DSU_OP_LOGIC: begin
                    r = {{`DSU_GUARD_W{1'b0}}, l_res,
                         {`DSU_WORD_W{1'b0}}};
                    last = l_last;
                    f.neg = r[`DSU_BASE_MSB];
                    f.zero = (l_res == '0);
                    f.ovf = 1'b0;
                    f.greater_than_flag = 1'b0;
                    st_nxt.guard_we = DST_HAS_GUARD;
                end
                default: begin
                    st_nxt.valid = 1'b0;
                    st_nxt.flags_we = 1'b0;
                end
            endcase
            // Selectable flag by condition mode
            case (COND_SELECT)
                DSU_CS_CARRY_M: f.selectable_condition_flag = last;
                DSU_CS_NEG_M: f.selectable_condition_flag = f.neg;
                DSU_CS_ZERO_M: f.selectable_condition_flag = f.zero;
                DSU_CS_OVF_M: f.selectable_condition_flag = f.ovf;
                default: f.selectable_condition_flag = 1'b0;
            endcase
            // An unknown kind leaves the last result standing
            if (st_nxt.valid) begin
                st_nxt.result = r;
            end
            if (st_nxt.flags_we) begin
                st_nxt.flags = f;
            end
        end
    end

    // Register the whole state
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign RESULT_VALID = st_r.valid;
    assign RESULT = st_r.result;
    assign GUARD_WRITE = st_r.guard_we;
    assign FLAGS_UPDATE = st_r.flags_we;
    assign FLAGS = st_r.flags;

    // Checks on the datapath
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);

    // Issue of a kind that the unit executes
    assign op_legal = OP_VALID &&
        (OP_KIND == DSU_OP_ARITH || OP_KIND == DSU_OP_LOGIC);

    chk_cond_flags_hold: assert property (
        OP_VALID && COND_OP |=> $stable(FLAGS) && !FLAGS_UPDATE)
        else $error("flags changed on conditional shift");

    chk_uncond_update: assert property (
        op_legal && !COND_OP |=> FLAGS_UPDATE && RESULT_VALID)
        else $error("unconditional shift did not update flags");

    chk_logic_clear: assert property (
        OP_VALID && OP_KIND == DSU_OP_LOGIC
        |=> RESULT[15:0] == 16'h0000 && RESULT[39:32] == 8'h00)
        else $error("logical shift left lower word or guard bits");

    chk_logic_flags: assert property (
        OP_VALID && !COND_OP && OP_KIND == DSU_OP_LOGIC
        |=> !FLAGS.ovf && !FLAGS.greater_than_flag)
        else $error("logical shift set overflow or greater-than");

    chk_logic_neg: assert property (
        OP_VALID && !COND_OP && OP_KIND == DSU_OP_LOGIC
        |=> FLAGS.neg == RESULT[31])
        else $error("negative flag not bit 31 after logical shift");

    chk_sat_no_ovf: assert property (
        OP_VALID && !COND_OP && SAT_ENABLE && OP_KIND == DSU_OP_ARITH
        |=> !FLAGS.ovf)
        else $error("overflow reported while saturating");

    chk_sat_clamp: assert property (
        OP_VALID && SAT_ENABLE && OP_KIND == DSU_OP_ARITH && a_ovf
        |=> RESULT == 40'h007fffffff || RESULT == 40'hff80000000)
        else $error("saturated result not clamped");

    chk_zero_flag: assert property (
        OP_VALID && !COND_OP && OP_KIND == DSU_OP_ARITH
        |=> FLAGS.zero == (RESULT == 40'h0000000000))
        else $error("zero flag disagrees with result");

    chk_above_mode_sel: assert property (
        op_legal && !COND_OP && COND_SELECT == DSU_CS_ABOVE_M
        |=> !FLAGS.selectable_condition_flag && !FLAGS.greater_than_flag)
        else $error("selectable flag set in greater-than mode");

    chk_guard_fill: assert property (
        OP_VALID && !SRC_HAS_GUARD && OP_KIND == DSU_OP_ARITH
        && USE_LITERAL && ARITH_SHIFT_LITERAL == 7'h00 && !SAT_ENABLE
        |=> RESULT[39:31] == {9{$past(FIRST_SOURCE[31])}})
        else $error("guard bits not sign filled");

    chk_one_cycle: assert property (
        !OP_VALID |=> !RESULT_VALID && !FLAGS_UPDATE)
        else $error("result without issue");

    chk_carry_left1: assert property (
        OP_VALID && !COND_OP && OP_KIND == DSU_OP_LOGIC && USE_LITERAL
        && LOGIC_SHIFT_LITERAL == 6'h01 && COND_SELECT == DSU_CS_CARRY_M
        |=> FLAGS.selectable_condition_flag == $past(FIRST_SOURCE[31]))
        else $error("carry mode lost last bit out");

    chk_arith_neg: assert property (
        op_legal && !COND_OP && OP_KIND == DSU_OP_ARITH
        |=> FLAGS.neg == RESULT[39])
        else $error("negative flag disagrees with result sign");

    chk_neg_mode_sel: assert property (
        op_legal && !COND_OP && COND_SELECT == DSU_CS_NEG_M
        |=> FLAGS.selectable_condition_flag == FLAGS.neg)
        else $error("selectable flag differs from negative flag");

    chk_zero_mode_sel: assert property (
        op_legal && !COND_OP && COND_SELECT == DSU_CS_ZERO_M
        |=> FLAGS.selectable_condition_flag == FLAGS.zero)
        else $error("selectable flag differs from zero flag");

    chk_ovf_mode_sel: assert property (
        op_legal && !COND_OP && COND_SELECT == DSU_CS_OVF_M
        |=> FLAGS.selectable_condition_flag == FLAGS.ovf)
        else $error("selectable flag differs from overflow flag");

    chk_guard_write: assert property (
        op_legal
        |=> GUARD_WRITE == $past(DST_HAS_GUARD))
        else $error("guard write does not follow destination kind");

    chk_logic_upper: assert property (
        op_legal && OP_KIND == DSU_OP_LOGIC && USE_LITERAL
        && LOGIC_SHIFT_LITERAL == 6'h00
        |=> RESULT[31:16] == $past(FIRST_SOURCE[31:16]))
        else $error("logical shift by zero changed the upper word");

    chk_result_hold: assert property (
        !RESULT_VALID |-> $stable(RESULT))
        else $error("result changed without a valid op");

    chk_sat_sign: assert property (
        op_legal && SAT_ENABLE && OP_KIND == DSU_OP_ARITH && a_ovf
        |=> RESULT[39] == $past(a_src[39]))
        else $error("saturated result has the wrong sign");

    chk_gt_clear: assert property (
        FLAGS_UPDATE |-> !FLAGS.greater_than_flag)
        else $error("greater-than flag set by a shift");

    cov_arith_left: cover property (
        OP_VALID && OP_KIND == DSU_OP_ARITH && !a_amt[6] ##1 RESULT_VALID);
    cov_arith_sat: cover property (
        OP_VALID && SAT_ENABLE && a_ovf ##1 RESULT_VALID);
    cov_logic_right: cover property (
        OP_VALID && OP_KIND == DSU_OP_LOGIC && l_amt[5] ##1 RESULT_VALID);
    cov_cond_shift: cover property (
        OP_VALID && COND_OP ##1 RESULT_VALID && !FLAGS_UPDATE);
    cov_sat_neg: cover property (
        op_legal && SAT_ENABLE && a_ovf && a_src[39] ##1 RESULT_VALID);

endmodule : dsu_shift_unit

// [tb/dsu_pipe_model.sv]
// Purpose: Issue side of the pipeline that feeds the shift unit
// Assumes: Ops are launched on the falling edge of the clock
// Notes: Unused amount lines carry noise so stale values never help
`timescale 1ns/1ns
`include "dsu_params.svh"

module dsu_pipe_model (
    // Clock
    input wire logic clk,
    // Issue lines towards the shift unit
    output logic op_valid = 1'b0,
    output dsu_pkg::dsu_op_e op_kind = dsu_pkg::DSU_OP_ARITH,
    output logic cond_op = 1'b0,
    output logic use_lit = 1'b0,
    output logic [6:0] ash_lit = 7'h00,
    output logic [5:0] lsh_lit = 6'h00,
    output logic [39:0] src1 = 40'h0,
    output logic [39:0] src2 = 40'h0,
    output logic src_g = 1'b0,
    output logic dst_g = 1'b0,
    output dsu_pkg::dsu_cs_e cond_sel = dsu_pkg::DSU_CS_CARRY_M,
    output logic sat_en = 1'b0
);
    import dsu_pkg::*;

    // Limit an amount to the span that software may legally issue
    function automatic int clip(input int x, input int lim);
        return (x > lim) ? lim : (x < -lim) ? -lim : x;
    endfunction : clip

    // Launch one op at the next falling edge
    task automatic issue(input logic v, input logic [1:0] k, input logic c,
        input logic lit, input int amt, input logic [39:0] fs,
        input logic sg, input logic dg, input logic [2:0] cs,
        input logic sat, input logic [31:0] nz);
        int a;
        logic [39:0] ss;
        a = (k == 2'h2) ? clip(amt, 16) : clip(amt, 32);
        ss = {nz[7:0], nz};
        if (!lit) begin
            ss[22:16] = (k == 2'h2) ? {nz[9], a[5:0]} : a[6:0];
        end
        @(negedge clk);
        op_valid = v;
        op_kind = dsu_op_e'(k);
        cond_op = c;
        use_lit = lit;
        ash_lit = lit ? a[6:0] : nz[6:0];
        lsh_lit = lit ? a[5:0] : nz[5:0];
        src1 = fs; // Literal forms get the destination's value
        src2 = ss;
        src_g = sg;
        dst_g = dg;
        cond_sel = dsu_cs_e'(cs);
        sat_en = sat;
    endtask : issue
endmodule : dsu_pipe_model

// [tb/dsu_shift_unit_tb_top.sv]
// Purpose: Self-checking bench of the DSP shift datapath
// Assumes: Results appear at the rising edge that follows the issuing falling edge
// Notes: Expected values come from the bench's own shift model
`timescale 1ns/1ns
`include "dsu_params.svh"

module dsu_shift_unit_tb_top;
    import dsu_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic op_valid, cond_op, use_lit, src_g, dst_g, sat_en;
    dsu_op_e op_kind;
    dsu_cs_e cond_sel;
    logic [6:0] ash_lit;
    logic [5:0] lsh_lit;
    logic [39:0] src1, src2, result, exp_res;
    logic result_valid, guard_write, flags_update;
    dsu_flags_s flags, exp_flg;
    logic [31:0] lfsr = 32'h3be0;
    int n_errors = 0;
    int checked = 0;
    int amt_tab[12] = '{32, -32, 0, 31, 1, -1, 16, -16, 0, 15, 1, -1};

    // Clock at 25 MHz
    always #20 sys_clk = ~sys_clk;

    dsu_pipe_model pm (.clk(sys_clk), .op_valid(op_valid),
        .op_kind(op_kind), .cond_op(cond_op), .use_lit(use_lit),
        .ash_lit(ash_lit), .lsh_lit(lsh_lit), .src1(src1), .src2(src2),
        .src_g(src_g), .dst_g(dst_g), .cond_sel(cond_sel),
        .sat_en(sat_en));

    dsu_shift_unit DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n),
        .OP_VALID(op_valid), .OP_KIND(op_kind), .COND_OP(cond_op),
        .USE_LITERAL(use_lit), .ARITH_SHIFT_LITERAL(ash_lit),
        .LOGIC_SHIFT_LITERAL(lsh_lit), .FIRST_SOURCE(src1),
        .SECOND_SOURCE(src2), .SRC_HAS_GUARD(src_g),
        .DST_HAS_GUARD(dst_g), .COND_SELECT(cond_sel),
        .SAT_ENABLE(sat_en), .RESULT_VALID(result_valid),
        .RESULT(result), .GUARD_WRITE(guard_write),
        .FLAGS_UPDATE(flags_update), .FLAGS(flags));

    // Next value of the stimulus generator
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd

    // Expected {result, flags} of one executed shift
    function automatic logic [44:0] model(input logic [1:0] k, input int a,
        input logic [39:0] fs, input logic sg, input logic [2:0] cs,
        input logic sat);
        logic [79:0] v;
        logic [39:0] s;
        logic lo, ov, ng, zr, sl;
        if (k == 2'h2) begin
            lo = (a > 0) ? fs[32 - a] : (a < 0) ? fs[15 - a] : 1'b0;
            s = {8'h00, (a < 0) ? fs[31:16] >> -a : fs[31:16] << a, 16'h0};
            ov = 1'b0;
            ng = s[31];
        end else begin
            s = sg ? fs : {{8{fs[31]}}, fs[31:0]};
            lo = (a > 0) ? s[40 - a] : (a < 0) ? s[-a - 1] : 1'b0;
            v = {{40{s[39]}}, s};
            if (a < 0) v = $signed(v) >>> -a; else v = v << a;
            ov = v[79:31] != {49{v[79]}};
            s = (sat && ov) ? (s[39] ? `DSU_SAT_NEG : `DSU_SAT_POS)
                : v[39:0];
            ov = ov && !sat;
            ng = s[39];
        end
        zr = (s == 40'h0);
        sl = (cs == 3'h0) ? lo : (cs == 3'h1) ? ng : (cs == 3'h2) ? zr
            : (cs == 3'h3) ? ov : 1'b0;
        return {s, sl, ng, zr, ov, 1'b0};
    endfunction : model

    // One compare with report
    task automatic chk(input string what, input logic [39:0] e, g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // Issue one op, then check the answer just after the next rising edge
    task automatic step(input logic v, input logic [1:0] k, input logic c,
        input logic lit, input int a, input logic [39:0] fs,
        input logic sg, input logic dg, input logic [2:0] cs,
        input logic sat);
        logic [44:0] e;
        logic live;
        live = v && (k == 2'h1 || k == 2'h2);
        e = model(k, a, fs, sg, cs, sat);
        pm.issue(v, k, c, lit, a, fs, sg, dg, cs, sat, rnd());
        @(posedge sys_clk);
        #1;
        if (live) begin
            exp_res = e[44:5];
            if (!c) exp_flg = e[4:0];
        end
        chk("valid", 40'(live), 40'(result_valid));
        chk("flags_update", 40'(live && !c), 40'(flags_update));
        if (live) chk("guard_write", 40'(dg), 40'(guard_write));
        chk("result", exp_res, result);
        chk("flags", 40'(exp_flg), 40'(flags));
    endtask : step

    // Reset for three cycles and check the cleared outputs
    task automatic do_reset;
        reset_n = 1'b0;
        @(posedge sys_clk);
        #1;
        exp_res = 40'h0;
        exp_flg = 5'h00;
        chk("reset result", 40'h0, result);
        chk("reset flags", 40'h0, 40'(flags));
        repeat (3) @(negedge sys_clk);
        reset_n = 1'b1;
    endtask : do_reset

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    // Watchdog well beyond the expected run time
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        logic [39:0] fs;
        logic [1:0] k;
        logic sg;
        int a;
        int j;
        do_reset();
        step(1, 2'h1, 0, 1, 4, 40'h1, 1, 1, 3'h2, 0);
        step(1, 2'h2, 0, 1, -1, 40'h0080010000, 1, 0, 3'h0, 0);
        step(1, 2'h1, 1, 0, 8, 40'h00c0000000, 0, 1, 3'h3, 0);
        step(0, 2'h1, 0, 0, 1, 40'h5, 1, 1, 3'h1, 0);
        step(1, 2'h0, 0, 0, 1, 40'h5, 1, 1, 3'h1, 0);
        step(1, 2'h3, 0, 0, 1, 40'h5, 1, 1, 3'h1, 0);
        $display("walk and idle test done");
        for (int i = 0; i < 72; i++) begin
            j = i / 12 % 6;
            fs = j[0] ? 40'h00c0008001 : 40'hff3fff7ffe;
            step(1, i[0] ? 2'h2 : 2'h1, 0, i[5], amt_tab[j + 6 * (i % 2)],
                fs, i[3], i[4], 3'(i / 2 % 6), i[2] ^ i[3]);
        end
        $display("mode and boundary test done");
        for (int i = 0; i < 400; i++) begin
            r = rnd();
            k = (r[2:0] == 3'h0) ? r[4:3] : {r[5], ~r[5]};
            a = (k == 2'h2) ? int'(rnd() % 33) - 16 : int'(rnd() % 65) - 32;
            fs = 40'({rnd(), rnd()});
            sg = r[8];
            if (r[6]) begin
                fs = exp_res;
                sg = r[7];
            end
            step(r[17:15] != 3'h0, k, r[10:9] == 2'h0, r[6], a, fs, sg,
                r[7], r[13:11], r[14]);
            if (i == 200) begin
                step(0, 2'h1, 0, 0, 0, 40'h0, 1, 1, 3'h0, 0);
                do_reset();
            end
        end
        $display("random test done");
        tally_and_finish();
    end
endmodule : dsu_shift_unit_tb_top
